// File: mscd_pkg.sv
package mscd_pkg;
  localparam int reading_width = 24;
  localparam int param_width = 4;
  localparam int buffer_depth = 8;
  localparam int buffer_ptr_width = 3;

  localparam logic [7:0] char_execute = 8'h58;
  localparam logic [7:0] char_function = 8'h46;
  localparam logic [7:0] char_range = 8'h52;
  localparam logic [7:0] char_zero = 8'h5a;
  localparam logic [7:0] char_suppress = 8'h4e;
  localparam logic [7:0] char_filter = 8'h50;
  localparam logic [7:0] char_digit_0 = 8'h30;
  localparam logic [7:0] char_digit_9 = 8'h39;
  localparam logic [7:0] char_upper_a = 8'h41;
  localparam logic [7:0] char_upper_z = 8'h5a;

  typedef enum logic [2:0] {
    mscd_op_function_type_unused,
    mscd_op_function,
    mscd_op_range,
    mscd_op_zero,
    mscd_op_suppress,
    mscd_op_filter
  } mscd_op_type;

  localparam logic func_capacitance = 1'b0;
  localparam logic func_current = 1'b1;
  localparam logic [3:0] range_min = 4'h1;
  localparam logic [3:0] range_cap_max = 4'h3;
  localparam logic [3:0] range_cur_max = 4'h8;
  localparam logic [3:0] zero_off = 4'h0;
  localparam logic [3:0] zero_on = 4'h1;
  localparam logic [3:0] zero_correct = 4'h2;
  localparam logic [3:0] suppress_off = 4'h0;
  localparam logic [3:0] suppress_on = 4'h1;
  localparam logic [3:0] filter_max = 4'h3;
  localparam logic [3:0] function_max = 4'h1;

  localparam logic reset_function = 1'b0;
  localparam logic [3:0] reset_range = 4'h3;
  localparam logic reset_zero_check = 1'b1;
  localparam logic reset_suppress = 1'b0;
  localparam logic [1:0] reset_filter = 2'h0;

  localparam logic [4:0] filter_shift_1 = 5'h02;
  localparam logic [4:0] filter_shift_2 = 5'h04;
  localparam logic [4:0] filter_shift_3 = 5'h06;
  localparam logic signed [23:0] full_scale_counts = 24'sh004e1f;
endpackage : mscd_pkg

// File: mscd_decoder.sv
// Behaviour
// - range code picks full scale per function, 1-3 capacitance, 1-8 current
// - in capacitance function range codes 4 to 8 clamp to code 3
// - after a range change the block restarts acquisition of a reading
// - power-up and bus clear set range code 3
// - zero command: 0 off, 1 on, 2 on plus offset correction
// - while zero check is on no readings are produced
// - zero correct captures present reading as offset, subtracted from later readings
// - offset is written to nonvolatile store and reloaded at power-up
// - zero correct is accepted with zero check on or off
// - power-up and bus clear turn zero check on
// - suppress on stores next reading as baseline, later readings minus baseline
// - baseline applies to capacitance and current, not the charge-rate reading
// - suppress during pending trigger lights indicator, capture waits for trigger
// - any function change cancels suppression
// - display blanks from suppress on until baseline captured
// - overrange flagged from raw reading before baseline subtraction
// - power-up and bus clear turn suppression off
// - filter command: 0 off, 1 and 2 changing inputs, 3 steady inputs
// - filter level 2 smooths heavier than level 1
// - power-up and bus clear turn filter off
// - commands are buffered and executed in order when execute character arrives
// - a buffered string executes only if every parameter in it was valid and fit the buffer; unknown command letters are skipped, not flagged
module mscd_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic bus_clear,
  input wire logic [7:0] cmd_char,
  input wire logic cmd_char_valid,
  output logic cmd_char_ready,
  input wire logic cmd_error_clear,
  output logic cmd_error,
  input wire logic trigger_pending,
  input wire logic reading_valid,
  input wire logic signed [23:0] raw_reading,
  input wire logic signed [23:0] charge_rate_reading,
  input wire logic signed [23:0] nv_offset_stored,
  output logic nv_offset_write,
  output logic signed [23:0] nv_offset_data,
  output logic function_select,
  output logic [3:0] range_code,
  output logic zero_check,
  output logic suppress_indicator,
  output logic display_blank,
  output logic [1:0] filter_level,
  output logic acquire_restart,
  output logic reading_out_valid,
  output logic signed [23:0] reading_out,
  output logic signed [23:0] charge_rate_out,
  output logic overrange
);
  typedef enum {exec_idle, exec_run} mscd_exec_type;
  typedef enum {parse_letter, parse_digit} mscd_parse_type;
  function automatic logic signed [23:0] mscd_sub(input logic signed [23:0] a,
                                                  input logic signed [23:0] b);
    logic signed [24:0] diff;
    diff = 25'(a) - 25'(b);
    return diff[23:0];
  endfunction : mscd_sub
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end
  mscd_exec_type exec_q;
  mscd_parse_type parse_q;
  mscd_pkg::mscd_op_type pend_op_q;
  mscd_pkg::mscd_op_type buf_op_q [mscd_pkg::buffer_depth];
  logic [3:0] buf_par_q [mscd_pkg::buffer_depth];
  logic [mscd_pkg::buffer_ptr_width:0] wr_cnt_q;
  logic [mscd_pkg::buffer_ptr_width:0] rd_ptr_q;
  logic string_bad_q, powerup_q, baseline_valid_q;
  logic signed [23:0] offset_q, baseline_q, last_raw_q;
  logic signed [31:0] filt_acc_q;
  logic take, is_digit, is_upper, param_ok, exec_go, step, bad_param;
  logic [3:0] digit;
  mscd_pkg::mscd_op_type cur_op;
  logic [3:0] cur_par;
  assign cmd_char_ready = (exec_q == exec_idle);
  assign take = clk_en && cmd_char_valid && cmd_char_ready;
  assign is_digit = (cmd_char >= mscd_pkg::char_digit_0) && (cmd_char <= mscd_pkg::char_digit_9);
  assign is_upper = (cmd_char >= mscd_pkg::char_upper_a) && (cmd_char <= mscd_pkg::char_upper_z);
  assign digit = 4'(cmd_char - mscd_pkg::char_digit_0);
  assign step = clk_en && (exec_q == exec_run);
  assign cur_op = buf_op_q[rd_ptr_q[mscd_pkg::buffer_ptr_width-1:0]];
  assign cur_par = buf_par_q[rd_ptr_q[mscd_pkg::buffer_ptr_width-1:0]];
  always_comb begin
    case (pend_op_q)
      mscd_pkg::mscd_op_function: param_ok = digit <= mscd_pkg::function_max;
      mscd_pkg::mscd_op_range: param_ok = (digit >= mscd_pkg::range_min) &&
                                          (digit <= mscd_pkg::range_cur_max);
      mscd_pkg::mscd_op_zero: param_ok = digit <= mscd_pkg::zero_correct;
      mscd_pkg::mscd_op_suppress: param_ok = digit <= mscd_pkg::suppress_on;
      mscd_pkg::mscd_op_filter: param_ok = digit <= mscd_pkg::filter_max;
      default: param_ok = 1'b0;
    endcase
  end
  // parser: letter then one digit, pushed into the command buffer
  assign bad_param = take && (parse_q == parse_digit) && !(is_digit && param_ok);
  assign exec_go = take && (parse_q == parse_letter) && (cmd_char == mscd_pkg::char_execute)
                   && !string_bad_q && (wr_cnt_q != '0);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      parse_q <= parse_letter;
      pend_op_q <= mscd_pkg::mscd_op_function_type_unused;
      wr_cnt_q <= '0;
      string_bad_q <= 1'b0;
    end else if (clk_en) begin
      if (bus_clear) begin
        parse_q <= parse_letter;
        wr_cnt_q <= '0;
        string_bad_q <= 1'b0;
      end else if (step && (rd_ptr_q + 1'b1 == wr_cnt_q)) begin
        wr_cnt_q <= '0;
      end else if (take && parse_q == parse_letter) begin
        if (cmd_char == mscd_pkg::char_execute) begin
          string_bad_q <= 1'b0;
          if (string_bad_q) begin
            wr_cnt_q <= '0;
          end
        end else if (is_upper) begin
          parse_q <= parse_digit;
          case (cmd_char)
            mscd_pkg::char_function: pend_op_q <= mscd_pkg::mscd_op_function;
            mscd_pkg::char_range: pend_op_q <= mscd_pkg::mscd_op_range;
            mscd_pkg::char_zero: pend_op_q <= mscd_pkg::mscd_op_zero;
            mscd_pkg::char_suppress: pend_op_q <= mscd_pkg::mscd_op_suppress;
            mscd_pkg::char_filter: pend_op_q <= mscd_pkg::mscd_op_filter;
            default: parse_q <= parse_letter;
          endcase
        end
      end else if (take && parse_q == parse_digit) begin
        parse_q <= parse_letter;
        if (!(is_digit && param_ok)) begin
          string_bad_q <= 1'b1;
        end else if (wr_cnt_q == 4'(mscd_pkg::buffer_depth)) begin
          string_bad_q <= 1'b1;
        end else begin
          wr_cnt_q <= wr_cnt_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && take && parse_q == parse_digit && is_digit && param_ok &&
        wr_cnt_q != 4'(mscd_pkg::buffer_depth)) begin
      buf_op_q[wr_cnt_q[mscd_pkg::buffer_ptr_width-1:0]] <= pend_op_q;
      buf_par_q[wr_cnt_q[mscd_pkg::buffer_ptr_width-1:0]] <= digit;
    end
  end

  // executor: one buffered command per cycle, oldest first
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      exec_q <= exec_idle;
      rd_ptr_q <= '0;
    end else if (clk_en) begin
      case (exec_q)
        exec_idle: begin
          rd_ptr_q <= '0;
          if (exec_go && !bus_clear) begin
            exec_q <= exec_run;
          end
        end
        exec_run: begin
          rd_ptr_q <= rd_ptr_q + 1'b1;
          if (bus_clear || rd_ptr_q + 1'b1 == wr_cnt_q) begin
            exec_q <= exec_idle;
          end
        end
        default: exec_q <= exec_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_error <= 1'b0;
    end else if (clk_en) begin
      if (bad_param) begin
        cmd_error <= 1'b1;
      end else if (cmd_error_clear) begin
        cmd_error <= 1'b0;
      end
    end
  end

  // settings
  logic zero_correct_go, suppress_go;
  assign zero_correct_go = step && cur_op == mscd_pkg::mscd_op_zero &&
                           cur_par == mscd_pkg::zero_correct;
  assign suppress_go = step && cur_op == mscd_pkg::mscd_op_suppress &&
                       cur_par == mscd_pkg::suppress_on;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      function_select <= mscd_pkg::reset_function;
      range_code <= mscd_pkg::reset_range;
      zero_check <= mscd_pkg::reset_zero_check;
      filter_level <= mscd_pkg::reset_filter;
      acquire_restart <= 1'b0;
    end else if (clk_en) begin
      acquire_restart <= 1'b0;
      if (bus_clear) begin
        function_select <= mscd_pkg::reset_function;
        range_code <= mscd_pkg::reset_range;
        zero_check <= mscd_pkg::reset_zero_check;
        filter_level <= mscd_pkg::reset_filter;
      end else if (step) begin
        case (cur_op)
          mscd_pkg::mscd_op_function: begin
            function_select <= cur_par[0];
            acquire_restart <= 1'b1;
            if (cur_par[0] == mscd_pkg::func_capacitance &&
                range_code > mscd_pkg::range_cap_max) begin
              range_code <= mscd_pkg::range_cap_max;
            end
          end
          mscd_pkg::mscd_op_range: begin
            acquire_restart <= 1'b1;
            if (function_select == mscd_pkg::func_capacitance &&
                cur_par > mscd_pkg::range_cap_max) begin
              range_code <= mscd_pkg::range_cap_max;
            end else begin
              range_code <= cur_par;
            end
          end
          mscd_pkg::mscd_op_zero: zero_check <= (cur_par != mscd_pkg::zero_off);
          mscd_pkg::mscd_op_filter: filter_level <= cur_par[1:0];
          default: acquire_restart <= 1'b0;
        endcase
      end
    end
  end

  // suppress and baseline
  logic func_change, baseline_take;
  assign func_change = step && cur_op == mscd_pkg::mscd_op_function &&
                       cur_par[0] != function_select;
  assign baseline_take = reading_valid && !trigger_pending && !zero_check &&
                         suppress_indicator && !baseline_valid_q;
  assign display_blank = suppress_indicator && !baseline_valid_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      suppress_indicator <= mscd_pkg::reset_suppress;
      baseline_valid_q <= 1'b0;
      baseline_q <= '0;
    end else if (clk_en) begin
      if (bus_clear || func_change) begin
        suppress_indicator <= mscd_pkg::reset_suppress;
        baseline_valid_q <= 1'b0;
      end else if (suppress_go) begin
        suppress_indicator <= 1'b1;
        baseline_valid_q <= 1'b0;
      end else if (step && cur_op == mscd_pkg::mscd_op_suppress) begin
        suppress_indicator <= 1'b0;
        baseline_valid_q <= 1'b0;
      end else if (baseline_take) begin
        baseline_q <= mscd_sub(raw_reading, offset_q);
        baseline_valid_q <= 1'b1;
      end
    end
  end

  // zero-correction offset with nonvolatile copy
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      powerup_q <= 1'b1;
      offset_q <= '0;
      last_raw_q <= '0;
      nv_offset_write <= 1'b0;
      nv_offset_data <= '0;
    end else if (clk_en) begin
      nv_offset_write <= 1'b0;
      powerup_q <= 1'b0;
      if (reading_valid) begin
        last_raw_q <= raw_reading;
      end
      if (powerup_q) begin
        offset_q <= nv_offset_stored;
      end else if (zero_correct_go) begin
        offset_q <= last_raw_q;
        nv_offset_data <= last_raw_q;
        nv_offset_write <= 1'b1;
      end
    end
  end

  // reading path: offset, baseline, filter
  logic signed [23:0] corrected, base_sel;
  logic signed [31:0] filt_in, filt_next;
  logic [4:0] shift;
  assign base_sel = baseline_take ? mscd_sub(raw_reading, offset_q) :
                    baseline_valid_q ? baseline_q : 24'sh000000;
  assign corrected = mscd_sub(mscd_sub(raw_reading, offset_q), base_sel);
  assign filt_in = 32'(corrected);
  always_comb begin
    case (filter_level)
      2'h1: shift = mscd_pkg::filter_shift_1;
      2'h2: shift = mscd_pkg::filter_shift_2;
      2'h3: shift = mscd_pkg::filter_shift_3;
      default: shift = 5'h00;
    endcase
  end
  assign filt_next = (filter_level == 2'h0) ? filt_in :
                     filt_acc_q + ((filt_in - filt_acc_q) >>> shift);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      filt_acc_q <= '0;
      reading_out_valid <= 1'b0;
      reading_out <= '0;
      charge_rate_out <= '0;
      overrange <= 1'b0;
    end else if (clk_en) begin
      reading_out_valid <= 1'b0;
      if (reading_valid && !zero_check) begin
        filt_acc_q <= filt_next;
        reading_out <= filt_next[23:0];
        charge_rate_out <= charge_rate_reading;
        reading_out_valid <= !display_blank || baseline_take;
        overrange <= (raw_reading > mscd_pkg::full_scale_counts) ||
                     (raw_reading < -mscd_pkg::full_scale_counts);
      end
    end
  end
endmodule : mscd_decoder

// File: mscd_decoder_properties.sv
module mscd_decoder_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic bus_clear,
  input wire logic reading_valid,
  input wire logic signed [23:0] raw_reading,
  input wire logic signed [23:0] charge_rate_reading,
  input wire logic nv_offset_write,
  input wire logic function_select,
  input wire logic [3:0] range_code,
  input wire logic zero_check,
  input wire logic suppress_indicator,
  input wire logic display_blank,
  input wire logic [1:0] filter_level,
  input wire logic acquire_restart,
  input wire logic reading_out_valid,
  input wire logic signed [23:0] charge_rate_out,
  input wire logic overrange
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic taken;
  assign taken = reading_valid && clk_en && !zero_check && !display_blank && !bus_clear;
  property p_range_legal;
    range_code >= mscd_pkg::range_min && range_code <= mscd_pkg::range_cur_max;
  endproperty
  a_range_legal: assert property (p_range_legal) else $error("range code illegal");
  property p_cap_clamp;
    function_select == mscd_pkg::func_capacitance |-> range_code <= mscd_pkg::range_cap_max;
  endproperty
  a_cap_clamp: assert property (p_cap_clamp) else $error("cap range above 3");
  property p_restart;
    $changed(range_code) && !$past(bus_clear) |-> acquire_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on range change");
  property p_standby;
    reading_valid && zero_check |=> !reading_out_valid;
  endproperty
  a_standby: assert property (p_standby) else $error("reading in zero check");
  property p_rate_plain;
    taken |=> reading_out_valid && charge_rate_out == $past(charge_rate_reading);
  endproperty
  a_rate_plain: assert property (p_rate_plain) else $error("charge rate altered");
  property p_over;
    taken && (raw_reading > mscd_pkg::full_scale_counts
      || raw_reading < -mscd_pkg::full_scale_counts) |=> overrange;
  endproperty
  a_over: assert property (p_over) else $error("overrange missed");
  property p_func_cancel;
    $changed(function_select) |-> !suppress_indicator;
  endproperty
  a_func_cancel: assert property (p_func_cancel) else $error("suppress kept");
  property p_blank;
    display_blank |-> suppress_indicator;
  endproperty
  a_blank: assert property (p_blank) else $error("blank without suppress");
  property p_clear;
    bus_clear && clk_en |=> range_code == mscd_pkg::reset_range && zero_check
      && !suppress_indicator && filter_level == mscd_pkg::reset_filter && !function_select;
  endproperty
  a_clear: assert property (p_clear) else $error("clear defaults wrong");
  property p_nv_write;
    nv_offset_write |-> zero_check;
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("offset store without zero check");
  c_restart: cover property (acquire_restart);
  c_nv: cover property (nv_offset_write);
  c_over: cover property (overrange && reading_out_valid);
  c_blank: cover property (display_blank);
endmodule : mscd_decoder_checker

bind mscd_decoder mscd_decoder_checker i_chk (.clk, .reset_n, .clk_en, .bus_clear,
  .reading_valid, .raw_reading, .charge_rate_reading, .nv_offset_write, .function_select,
  .range_code, .zero_check, .suppress_indicator, .display_blank, .filter_level,
  .acquire_restart, .reading_out_valid, .charge_rate_out, .overrange);

// File: mscd_host.sv
module mscd_host (
  input wire logic clk,
  output logic [7:0] cmd_char,
  output logic cmd_char_valid,
  input wire logic cmd_char_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_char = 8'h00;
    cmd_char_valid = 1'b0;
  end
  // chars held until taken or 50 cycles pass, sent in order
  task automatic send(input string s, input int gap);
    int n;
    logic rdy;
    for (int i = 0; i < s.len(); i++) begin
      cmd_char <= s[i];
      cmd_char_valid <= 1'b1;
      n = 0;
      do begin
        @(negedge clk);
        rdy = cmd_char_ready;
        @(posedge clk);
        n++;
      end while (!rdy && n < 50);
      if (i == s.len() - 1 || gap > 0) begin
        cmd_char_valid <= 1'b0;
        cmd_char <= ~s[i];
        repeat (gap) @(posedge clk);
      end
    end
  endtask : send
endmodule : mscd_host

// File: tb_meter_setup_command_decoder.sv
module tb_meter_setup_command_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, clk_en, bus_clear, cmd_char_valid, cmd_char_ready, cmd_error_clear;
  logic cmd_error, trigger_pending, reading_valid, nv_offset_write, function_select;
  logic zero_check, suppress_indicator, display_blank, acquire_restart, reading_out_valid;
  logic overrange;
  logic [7:0] cmd_char;
  logic [3:0] range_code;
  logic [1:0] filter_level;
  logic signed [23:0] raw_reading, charge_rate_reading, nv_offset_stored, nv_offset_data;
  logic signed [23:0] reading_out, charge_rate_out, off, r;
  logic signed [23:0] exp_q[$];
  int fails, compares, cycles;
  mscd_decoder i_dut (.clk, .reset_n, .clk_en, .bus_clear, .cmd_char, .cmd_char_valid,
    .cmd_char_ready, .cmd_error_clear, .cmd_error, .trigger_pending, .reading_valid,
    .raw_reading, .charge_rate_reading, .nv_offset_stored, .nv_offset_write,
    .nv_offset_data, .function_select, .range_code, .zero_check, .suppress_indicator,
    .display_blank, .filter_level, .acquire_restart, .reading_out_valid, .reading_out,
    .charge_rate_out, .overrange);
  mscd_host i_host (.clk(clk), .cmd_char(cmd_char), .cmd_char_valid(cmd_char_valid),
    .cmd_char_ready(cmd_char_ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] cf(logic f, logic [3:0] g, logic z, logic s, logic [1:0] p);
    return 32'({f, g, z, s, p});
  endfunction : cf
  function automatic logic [31:0] cfg();
    return cf(function_select, range_code, zero_check, suppress_indicator, filter_level);
  endfunction : cfg
  task automatic cmd(input string s);
    int n;
    n = 0;
    i_host.send(s, $urandom_range(0, 2));
    repeat (2) @(posedge clk);
    while (!cmd_char_ready && n < 40) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
  endtask : cmd
  task automatic rd(input logic signed [23:0] raw, input bit push, input logic signed [23:0] e);
    reading_valid <= 1'b1;
    raw_reading <= raw;
    charge_rate_reading <= 24'($urandom);
    if (push) exp_q.push_back(e);
    @(posedge clk);
    reading_valid <= 1'b0;
    raw_reading <= ~raw;
    repeat (3) @(posedge clk);
  endtask : rd
  // each produced reading matched against the oldest note
  always @(posedge clk) begin
    if (reading_out_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk(32'(reading_out), 32'(exp_q.pop_front()));
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(9087));
    reset_n = 1'b0;
    clk_en = 1'b1;
    bus_clear = 1'b0;
    cmd_error_clear = 1'b0;
    trigger_pending = 1'b0;
    reading_valid = 1'b0;
    raw_reading = '0;
    charge_rate_reading = '0;
    off = 24'($urandom_range(1, 255));
    nv_offset_stored = off;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(cfg(), cf(0, 3, 1, 0, 0));
    cmd("Z0X");
    chk(cfg(), cf(0, 3, 0, 0, 0));
    r = 24'($urandom_range(100, 5000));
    rd(r, 1, r - off);
    for (int i = 1; i <= 8; i++) begin
      cmd($sformatf("F1R%0dX", i));
      chk(cfg(), cf(1, 4'(i), 0, 0, 0));
      cmd($sformatf("F0R%0dX", i));
      chk(cfg(), cf(0, (i > 3) ? 4'h3 : 4'(i), 0, 0, 0));
    end
    cmd("R9X");
    chk(32'({cmd_error, range_code}), 32'h13);
    cmd_error_clear <= 1'b1;
    @(posedge clk);
    cmd_error_clear <= 1'b0;
    cmd("R1R9X");
    chk(32'({cmd_error, range_code}), 32'h13);
    cmd("R1XR2X");
    chk(32'(range_code), 32'h2);
    for (int i = 0; i <= 3; i++) begin
      cmd($sformatf("P%0dX", i));
      chk(32'(filter_level), 32'(i));
    end
    cmd("P0X");
    cmd("F1R1X");
    r = 24'($urandom_range(100, 5000));
    rd(r, 1, r - off);
    cmd("Z2X");
    chk(32'(zero_check), 32'h1);
    chk(32'(nv_offset_data), 32'(r));
    rd(r + 7, 0, 0);
    cmd("Z0X");
    rd(r + 3, 1, 3);
    trigger_pending <= 1'b1;
    cmd("N1X");
    chk(32'({suppress_indicator, display_blank}), 32'h3);
    rd(r + 50, 0, 0);
    trigger_pending <= 1'b0;
    rd(r + 50, 1, 0);
    chk(32'(display_blank), 32'h0);
    rd(r + 60, 1, 10);
    cmd("P2X");
    rd(r + 220, 1, 24'sd10 + (24'sd160 >>> mscd_pkg::filter_shift_2));
    cmd("P0X");
    rd(24'sd20000, 1, 24'sd20000 - r - 50);
    chk(32'(overrange), 32'h1);
    cmd("F0X");
    chk(32'(suppress_indicator), 32'h0);
    cmd("P2X");
    clk_en <= 1'b0;
    bus_clear <= 1'b1;
    @(posedge clk);
    bus_clear <= 1'b0;
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    chk(cfg(), cf(0, 1, 0, 0, 2));
    bus_clear <= 1'b1;
    @(posedge clk);
    bus_clear <= 1'b0;
    repeat (2) @(posedge clk);
    chk(cfg(), cf(0, 3, 1, 0, 0));
    chk(32'(exp_q.size()), 32'h0);
    wrap_up();
  end
endmodule : tb_meter_setup_command_decoder
